// file: logic/nsf_pkg.sv
// Constants, offsets and types shared by the navigation frame formatter.
// Assumes one 50 MHz clock, a synchronous active-high reset and an APB port.
// Notes on behaviour
// - Frame opens with f, m, i in bytes 1-3 and type n in byte 4.
// - Multi-byte fields go out least significant byte first.
// - Time at byte 5, position from 13, velocity from 37 and attitude from 49.
// - Accelerometer bias estimates sit at bytes 65, 69 and 73.
// - Gyro bias estimates at 77, 81, 85; steering Z bias at 89.
// - The 32-bit status word starts at byte 93.
// - 16-bit byte sum of bytes 1 to 89 at byte 97; tail e, d.
// - Status bit 0 initialising, bit 1 converged, bit 2 converging.
// - Status bit 3 tilt excess, bit 4 fix rejected, bit 5 reset pending.
// - Status bits 6-9 mounting phases 1-4, bit 10 mounting done.
// - While initialising only attitude is valid; position and velocity blanked.
// - Text messages carry Warning:, Error: or Info: and end in CR LF.
// - Text lines may also go out with no class prefix.
// - Error class is for serious faults; warnings may be ignored.
// - Output goes to serial port 1 or serial port 3.
// - Serial rate defaults to 115200 bits per second.
package nsf_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_BPS = 115_200;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_BPS);
    localparam logic [6:0] B_PAYLOAD = 7'h04;
    localparam logic [6:0] B_SUM_END = 7'h58;
    localparam logic [6:0] B_STATUS = 7'h5C;
    localparam logic [6:0] B_CSUM = 7'h60;
    localparam logic [6:0] B_TAIL = 7'h62;
    localparam logic [6:0] B_LAST = 7'h63;
    localparam logic [6:0] P_POS_FIRST = 7'h08;
    localparam logic [6:0] P_VEL_LAST = 7'h2B;
    localparam int SOL_WORDS = 22;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_IRQ = 12'h008;
    localparam logic [11:0] A_MASK = 12'h00C;
    localparam logic [11:0] A_BAUD = 12'h010;
    localparam logic [11:0] A_TEXT = 12'h014;
    localparam logic [11:0] A_FLAGS = 12'h018;
    localparam logic [11:0] A_SOL = 12'h040;
    localparam logic [11:0] A_TBUF = 12'h100;
    localparam int CTRL_P1 = 0;
    localparam int CTRL_P3 = 1;
    localparam int CTRL_GO_FRAME = 2;
    localparam int CTRL_GO_TEXT = 3;
    localparam int IRQ_W = 3;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_TEXT = 1;
    localparam int IRQ_REFUSED = 2;
    localparam int ST_INIT = 0;
    localparam logic [7:0] CH_F = 8'h66;
    localparam logic [7:0] CH_M = 8'h6D;
    localparam logic [7:0] CH_I = 8'h69;
    localparam logic [7:0] CH_N = 8'h6E;
    localparam logic [7:0] CH_E = 8'h65;
    localparam logic [7:0] CH_D = 8'h64;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [63:0] PFX_WARN = "Warning:";
    localparam logic [63:0] PFX_ERR = {"Error:", 16'h0000};
    localparam logic [63:0] PFX_INFO = {"Info:", 24'h000000};
    localparam logic [3:0] LEN_WARN = 4'h8;
    localparam logic [3:0] LEN_ERR = 4'h6;
    localparam logic [3:0] LEN_INFO = 4'h5;
    typedef enum logic [1:0] {
        MSG_NONE = 2'b00,
        MSG_WARN = 2'b01,
        MSG_ERR = 2'b10,
        MSG_INFO = 2'b11
    } nsf_class_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FRAME = 3'b001,
        S_PRE = 3'b010,
        S_BODY = 3'b011,
        S_END = 3'b100
    } nsf_state_e;
endpackage : nsf_pkg

// file: logic/nsf_byte_if.sv
// Byte stream from the formatter core to its output stage.
// Assumes both ends run on the same clock.
interface nsf_byte_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    logic sum_en;
    logic sum_clr;
    logic [15:0] sum;
    modport src (output data, valid, sum_en, sum_clr, input ready, sum);
    modport snk (input data, valid, sum_en, sum_clr, output ready, sum);
endinterface : nsf_byte_if

// file: logic/nsf_tx_stage.sv
// Output holding stage and running byte sum for the formatter.
// Assumes the serial transmitter drains tx_data with a valid/ready handshake.
module nsf_tx_stage
    import nsf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    nsf_byte_if.snk up,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    logic full_q;
    logic full_d;
    logic [7:0] data_q;
    logic [15:0] sum_q;
    logic [15:0] sum_d;
    wire take = up.valid && up.ready;

    // A single register keeps full throughput while letting the UART stall the core.
    assign up.ready = !full_q || tx_ready;
    assign full_d = take || (full_q && !tx_ready);
    assign sum_d = sum_q + {8'h00, up.data};
    assign up.sum = sum_q;
    assign tx_data = data_q;
    assign tx_valid = full_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            full_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            full_q <= full_d;
            if (take) begin
                data_q <= up.data;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || up.sum_clr) begin
            sum_q <= 16'h0000;
        end else if (take && up.sum_en) begin
            sum_q <= sum_d;
        end
    end
endmodule : nsf_tx_stage

// file: logic/nsf_formatter.sv
// Navigation solution frame and text message formatter with an APB register port.
// Assumes a byte-wide serial transmitter outside that honours tx_valid/tx_ready.
module nsf_formatter
    import nsf_pkg::*;
#(
    parameter int TEXT_DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic filter_init,
    input wire logic filter_converged,
    input wire logic filter_converging,
    input wire logic tilt_excess_flag,
    input wire logic satellite_fix_reject_flag,
    input wire logic filter_reset_pending_flag,
    input wire logic [3:0] mount_estimation_phase_flag,
    input wire logic mount_estimation_done_flag,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic port1_en,
    output logic port3_en,
    output logic [15:0] baud_div,
    output logic irq
);
    localparam int LW = $clog2(TEXT_DEPTH) + 1;

    initial begin
        if (TEXT_DEPTH < 2 || TEXT_DEPTH > 64 || (TEXT_DEPTH & (TEXT_DEPTH - 1)) != 0) begin
            $error("TEXT_DEPTH must be a power of two from 2 to 64.");
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] sel);
        return w[8*sel +: 8];
    endfunction : byte_of

    function automatic logic [3:0] pfx_len(input nsf_class_e c);
        logic [3:0] n;
        n = 4'h0;
        unique case (c)
            MSG_WARN: n = LEN_WARN;
            MSG_ERR: n = LEN_ERR;
            MSG_INFO: n = LEN_INFO;
            MSG_NONE: n = 4'h0;
        endcase
        return n;
    endfunction : pfx_len

    function automatic logic [7:0] pfx_char(input nsf_class_e c, input logic [2:0] i);
        logic [63:0] s;
        s = 64'h0;
        unique case (c)
            MSG_WARN: s = PFX_WARN;
            MSG_ERR: s = PFX_ERR;
            MSG_INFO: s = PFX_INFO;
            MSG_NONE: s = 64'h0;
        endcase
        return s[63 - 8 * i -: 8];
    endfunction : pfx_char

    logic [1:0] ctrl_q;
    logic [IRQ_W-1:0] irq_q;
    logic [IRQ_W-1:0] irq_d;
    logic [IRQ_W-1:0] mask_q;
    logic [15:0] baud_q;
    nsf_class_e cls_q;
    logic [LW-1:0] len_q;
    logic [31:0] sol_q [SOL_WORDS];
    logic [7:0] tbuf_q [TEXT_DEPTH];
    nsf_state_e state_q;
    nsf_state_e state_d;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [31:0] snap_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    nsf_byte_if bif ();

    nsf_tx_stage u_tx (
        .mclk(mclk),
        .rst(rst),
        .up(bif.snk),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    // Register decode.
    wire wr = psel && penable && pwrite;
    wire setup = psel && !penable;
    wire [11:0] sol_off = paddr - A_SOL;
    wire [11:0] tb_off = paddr - A_TBUF;
    wire hit_sol = sol_off < 12'(SOL_WORDS * 4);
    wire hit_tb = tb_off < 12'(TEXT_DEPTH * 4);
    wire [4:0] sol_widx = sol_off[6:2];
    wire [LW-2:0] tb_widx = tb_off[LW:2];
    wire hit_ctrl = paddr == A_CTRL;
    wire hit_irq = paddr == A_IRQ;
    wire hit_mask = paddr == A_MASK;
    wire hit_baud = paddr == A_BAUD;
    wire hit_text = paddr == A_TEXT;
    wire hit_reg = hit_ctrl || paddr == A_STAT || hit_irq || hit_mask || hit_baud || hit_text
                   || paddr == A_FLAGS;
    wire hit_any = hit_reg || hit_sol || hit_tb;
    wire [31:0] ctrl_w = merge({30'h0, ctrl_q}, pwdata, pstrb);
    wire [31:0] irq_wv = merge(32'h0, pwdata, pstrb);
    wire [31:0] text_w = merge(32'({len_q, 6'h0, cls_q}), pwdata, pstrb);

    // Live filter state word, assembled from the fusion engine flags.
    wire [31:0] flags_w = {21'h0, mount_estimation_done_flag,
                           mount_estimation_phase_flag,
                           filter_reset_pending_flag, satellite_fix_reject_flag, tilt_excess_flag,
                           filter_converging, filter_converged, filter_init};

    // Start requests.
    wire idle = state_q == S_IDLE;
    wire any_port = ctrl_q[CTRL_P1] || ctrl_q[CTRL_P3];
    wire go_frame = wr && hit_ctrl && pstrb[0] && pwdata[CTRL_GO_FRAME];
    wire go_text = wr && hit_ctrl && pstrb[0] && pwdata[CTRL_GO_TEXT];
    wire start_frame = go_frame && idle && any_port;
    wire start_text = go_text && !go_frame && idle && any_port;
    wire refused = (go_frame || go_text) && !(start_frame || start_text);
    wire accept = bif.valid && bif.ready;
    wire [3:0] plen = pfx_len(cls_q);
    wire text_empty = len_q == '0;

    // Frame byte selection.
    wire [6:0] pidx = cnt_q - B_PAYLOAD;
    wire in_payload = cnt_q >= B_PAYLOAD && cnt_q < B_STATUS;
    wire [4:0] sidx = (in_payload && pidx[6:2] < 5'(SOL_WORDS)) ? pidx[6:2] : 5'h00;
    wire [31:0] sol_w = sol_q[sidx];
    wire blank = snap_q[ST_INIT] && in_payload && pidx >= P_POS_FIRST && pidx <= P_VEL_LAST;
    wire [7:0] hdr_byte = (cnt_q[1:0] == 2'd0) ? CH_F :
                          (cnt_q[1:0] == 2'd1) ? CH_M :
                          (cnt_q[1:0] == 2'd2) ? CH_I : CH_N;
    wire [7:0] frame_byte = (cnt_q < B_PAYLOAD) ? hdr_byte :
                            blank ? 8'h00 :
                            in_payload ? byte_of(sol_w, pidx[1:0]) :
                            (cnt_q < B_CSUM) ? byte_of(snap_q, cnt_q[1:0]) :
                            (cnt_q == B_CSUM) ? bif.sum[7:0] :
                            (cnt_q == B_CSUM + 7'd1) ? bif.sum[15:8] :
                            (cnt_q == B_TAIL) ? CH_E : CH_D;
    wire [7:0] body_byte = tbuf_q[cnt_q[LW-2:0]];
    wire [7:0] end_byte = cnt_q[0] ? CH_LF : CH_CR;

    assign bif.valid = !idle;
    assign bif.sum_clr = start_frame;
    assign bif.sum_en = state_q == S_FRAME && cnt_q <= B_SUM_END;
    assign bif.data = (state_q == S_FRAME) ? frame_byte :
                      (state_q == S_PRE) ? pfx_char(cls_q, cnt_q[2:0]) :
                      (state_q == S_BODY) ? body_byte : end_byte;

    // Sequencer.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            S_IDLE: begin
                cnt_d = 7'h00;
                if (start_frame) begin
                    state_d = S_FRAME;
                end else if (start_text) begin
                    state_d = (plen != 4'h0) ? S_PRE : (text_empty ? S_END : S_BODY);
                end
            end
            S_FRAME: begin
                if (accept) begin
                    cnt_d = cnt_q + 7'd1;
                    if (cnt_q == B_LAST) begin
                        state_d = S_IDLE;
                    end
                end
            end
            S_PRE: begin
                if (accept) begin
                    cnt_d = cnt_q + 7'd1;
                    if (cnt_q == 7'(plen - 4'h1)) begin
                        cnt_d = 7'h00;
                        state_d = text_empty ? S_END : S_BODY;
                    end
                end
            end
            S_BODY: begin
                if (accept) begin
                    cnt_d = cnt_q + 7'd1;
                    if (cnt_q == 7'(len_q - 1'b1)) begin
                        cnt_d = 7'h00;
                        state_d = S_END;
                    end
                end
            end
            S_END: begin
                if (accept) begin
                    cnt_d = cnt_q + 7'd1;
                    if (cnt_q[0]) begin
                        state_d = S_IDLE;
                    end
                end
            end
            default: begin
                state_d = S_IDLE;
                cnt_d = 7'h00;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= S_IDLE;
            cnt_q <= 7'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // The status word is frozen at frame start so the status bytes and the blanking agree.
    always_ff @(posedge mclk) begin
        if (rst) begin
            snap_q <= 32'h0;
        end else if (start_frame) begin
            snap_q <= flags_w;
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    wire frame_done = state_q == S_FRAME && accept && cnt_q == B_LAST;
    wire text_done = state_q == S_END && accept && cnt_q[0];
    wire [IRQ_W-1:0] irq_set = {refused, text_done, frame_done};
    wire [IRQ_W-1:0] irq_clr = (wr && hit_irq) ? irq_wv[IRQ_W-1:0] : '0;
    assign irq_d = (irq_q & ~irq_clr) | irq_set;

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_q <= '0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Software-written control and configuration.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q <= 2'b00;
            mask_q <= '0;
            baud_q <= BAUD_DIV_RST;
            cls_q <= MSG_NONE;
            len_q <= '0;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_q <= ctrl_w[1:0];
            end
            if (hit_mask) begin
                mask_q <= irq_wv[IRQ_W-1:0];
            end
            if (hit_baud) begin
                baud_q <= 16'(merge({16'h0, baud_q}, pwdata, pstrb));
            end
            if (hit_text) begin
                cls_q <= nsf_class_e'(text_w[1:0]);
                len_q <= (text_w[8 +: LW] > LW'(TEXT_DEPTH)) ? LW'(TEXT_DEPTH) : text_w[8 +: LW];
            end
        end
    end

    // Solution words, low word of each double first.
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < SOL_WORDS; i++) begin
                sol_q[i] <= 32'h0;
            end
        end else if (wr && hit_sol) begin
            sol_q[sol_widx] <= merge(sol_q[sol_widx], pwdata, pstrb);
        end
    end

    // Text buffer; changing it during a message alters the bytes not yet sent.
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < TEXT_DEPTH; i++) begin
                tbuf_q[i] <= 8'h00;
            end
        end else if (wr && hit_tb && pstrb[0]) begin
            tbuf_q[tb_widx] <= pwdata[7:0];
        end
    end

    // Read data is captured in the setup cycle, so the access phase needs no wait.
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
                         (paddr == A_STAT) ? {28'h0, !idle, state_q} :
                         hit_irq ? {29'h0, irq_q} :
                         hit_mask ? {29'h0, mask_q} :
                         hit_baud ? {16'h0, baud_q} :
                         hit_text ? 32'({len_q, 6'h0, cls_q}) :
                         (paddr == A_FLAGS) ? flags_w :
                         hit_sol ? sol_q[sol_widx] :
                         hit_tb ? {24'h0, tbuf_q[tb_widx]} : 32'h0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata_q <= 32'h0;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_mux;
            slverr_q <= !hit_any;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = slverr_q && psel && penable;
    assign port1_en = ctrl_q[CTRL_P1];
    assign port3_en = ctrl_q[CTRL_P3];
    assign baud_div = baud_q;
    assign irq = |(irq_q & mask_q);
endmodule : nsf_formatter

// file: tb/nsf_host_model.sv
// Host receiver model that collects every byte handed over.
// Assumes the formatter's clock and synchronous reset.
module nsf_host_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic slow,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_q = 2'h0;
    logic [7:0] rx_q[$];
    initial tx_ready = 1'b0;
    // A slow host takes one byte in four, forcing stalls.
    always @(posedge mclk) begin
        if (rst) begin
            ph_q <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            tx_ready <= ~slow | (ph_q == 2'h1);
            if (tx_valid && tx_ready) begin
                rx_q.push_back(tx_data);
            end
        end
    end
endmodule : nsf_host_model

// file: tb/nsf_formatter_monitor.sv
// Port checker for the navigation frame formatter.
// Assumes no line feed inside a text body.
module nsf_formatter_monitor
    import nsf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pslverr,
    input wire logic filter_init,
    input wire logic filter_converged,
    input wire logic filter_converging,
    input wire logic tilt_excess_flag,
    input wire logic satellite_fix_reject_flag,
    input wire logic filter_reset_pending_flag,
    input wire logic [3:0] mount_estimation_phase_flag,
    input wire logic mount_estimation_done_flag,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic port1_en,
    input wire logic port3_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] fcnt_q;
    logic [6:0] fcnt_d;
    logic txt_q;
    logic txt_d;
    logic [15:0] sum_q;
    logic [15:0] sum_d;
    logic [31:0] snap_q;
    logic [1:0] cls_q;
    wire take = tx_valid & tx_ready;
    wire wr_ctl = psel & penable & pwrite & pstrb[0] & (paddr == A_CTRL);
    wire idle = (fcnt_q == 7'h00) & ~txt_q;
    wire ports = port1_en | port3_en;
    wire go_f = wr_ctl & pwdata[CTRL_GO_FRAME] & ports & idle;
    wire go_t = wr_ctl & pwdata[CTRL_GO_TEXT] & ~pwdata[CTRL_GO_FRAME] & ports & idle;
    wire [10:0] flags = {mount_estimation_done_flag, mount_estimation_phase_flag, filter_reset_pending_flag,
        satellite_fix_reject_flag, tilt_excess_flag, filter_converging, filter_converged, filter_init};
    wire [7:0] hd = (fcnt_q == 7'h01) ? CH_F : (fcnt_q == 7'h02) ? CH_M : (fcnt_q == 7'h03) ? CH_I : CH_N;
    wire [7:0] pf = (cls_q == 2'h1) ? PFX_WARN[63:56] : (cls_q == 2'h2) ? PFX_ERR[63:56] : PFX_INFO[63:56];
    wire counting = take & (fcnt_q != 7'h00);
    assign fcnt_d = go_f ? 7'h01 : counting ? ((fcnt_q == 7'h64) ? 7'h00 : fcnt_q + 7'h01) : fcnt_q;
    assign txt_d = go_t | (txt_q & ~(take & (tx_data == CH_LF)));
    assign sum_d = go_f ? 16'h0000 : (counting && fcnt_q <= 7'h59) ? sum_q + {8'h00, tx_data} : sum_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            fcnt_q <= 7'h00;
            txt_q <= 1'b0;
            sum_q <= 16'h0000;
        end else begin
            fcnt_q <= fcnt_d;
            txt_q <= txt_d;
            sum_q <= sum_d;
        end
    end
    // Read only while a message runs, so no reset is needed.
    always_ff @(posedge mclk) begin
        if (go_f) begin
            snap_q <= {21'h0, flags};
        end
        if (psel && penable && pwrite && pstrb[0] && paddr == A_TEXT) begin
            cls_q <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_first_byte: assert property (go_f |-> ##[1:2] tx_valid && tx_data == CH_F)
        else $error("header missing");
    a_head_bytes: assert property (take && fcnt_q >= 7'h01 && fcnt_q <= 7'h04 |-> tx_data == hd)
        else $error("bad header");
    a_status_bytes: assert property (take && fcnt_q >= 7'h5D && fcnt_q <= 7'h60 |->
        tx_data == snap_q[(fcnt_q - 7'h5D) * 8 +: 8])
        else $error("bad status");
    a_sum_bytes: assert property (take && (fcnt_q == 7'h61 || fcnt_q == 7'h62) |->
        tx_data == ((fcnt_q == 7'h61) ? sum_q[7:0] : sum_q[15:8]))
        else $error("bad checksum");
    a_tail_bytes: assert property (take && fcnt_q >= 7'h63 |-> tx_data == ((fcnt_q == 7'h63) ? CH_E : CH_D))
        else $error("bad tail");
    a_init_blank: assert property (take && snap_q[0] && fcnt_q >= 7'h0D && fcnt_q <= 7'h30 |-> tx_data == 8'h00)
        else $error("unblanked field");
    a_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("stall change");
    a_text_first: assert property (go_t && cls_q != 2'h0 |-> ##[1:2] tx_valid && tx_data == pf)
        else $error("bad prefix");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("stray error");
    c_frame: cover property (take && fcnt_q == 7'h64);
    c_init_frame: cover property (go_f && flags[0]);
    c_text: cover property (go_t && cls_q == 2'h2);
endmodule : nsf_formatter_monitor

// file: tb/nsf_formatter_test.sv
// Self-checking APB bench for the frame formatter.
// Assumes a 50 MHz clock; APB waits are handled.
module nsf_formatter_test
    import nsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [10:0] flg = 11'h000;
    logic slow = 1'b0;
    logic [31:0] prdata;
    logic [7:0] tx_data;
    logic [15:0] baud_div;
    logic pready, pslverr, tx_valid, tx_ready, port1_en, port3_en, irq;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int cmp_count = 0;
    string pfx[4] = '{"", "Warning:", "Error:", "Info:"};
    always #10 mclk = ~mclk;
    nsf_host_model host (.mclk, .rst, .tx_data, .tx_valid, .slow, .tx_ready);
    nsf_formatter #(.TEXT_DEPTH(32)) dut (.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
        .prdata, .pready, .pslverr, .filter_init(flg[0]), .filter_converged(flg[1]), .filter_converging(flg[2]),
        .tilt_excess_flag(flg[3]), .satellite_fix_reject_flag(flg[4]), .filter_reset_pending_flag(flg[5]),
        .mount_estimation_phase_flag(flg[9:6]), .mount_estimation_done_flag(flg[10]), .tx_data, .tx_valid,
        .tx_ready, .port1_en, .port3_en, .baud_div, .irq);
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Irq moves one edge after the clearing write, so it is sampled mid-cycle.
    task automatic irq_clear(input logic [31:0] st, input logic lvl);
        @(negedge mclk);
        chk("irq level", irq, lvl);
        apb(A_IRQ, 1'b0, 32'h0);
        chk("irq status", rd, st);
        apb(A_IRQ, 1'b1, st);
        @(negedge mclk);
        chk("irq cleared", irq, 1'b0);
    endtask : irq_clear
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 3000 && host.rx_q.size() < n; i++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        chk("byte count", host.rx_q.size(), n);
    endtask : wait_bytes
    function automatic logic [31:0] sw(input int k);
        return 32'h0102_0304 + 32'h1111_1111 * 32'(k);
    endfunction : sw
    task automatic frame(input logic [10:0] f, input logic [31:0] ctl);
        logic [7:0] e[1:100];
        logic [15:0] s;
        logic [31:0] v;
        flg <= f;
        slow <= ~f[0];
        host.rx_q.delete();
        apb(A_CTRL, 1'b1, ctl);
        wait_bytes(100);
        e[1] = CH_F;
        e[2] = CH_M;
        e[3] = CH_I;
        e[4] = CH_N;
        for (int k = 0; k < 24; k++) begin
            v = (k < 22) ? sw(k) : (k == 22) ? {21'h0, f} : 32'h0;
            for (int b = 0; b < 4; b++) e[5 + 4 * k + b] = (f[0] && k >= 2 && k < 11) ? 8'h00 : v[8 * b +: 8];
        end
        s = 16'h0000;
        for (int i = 1; i <= 89; i++) s += {8'h00, e[i]};
        e[97] = s[7:0];
        e[98] = s[15:8];
        e[99] = CH_E;
        e[100] = CH_D;
        for (int i = 1; i <= 100; i++) begin
            chk($sformatf("byte %0d", i), host.rx_q[i - 1], e[i]);
        end
        irq_clear(32'h1, 1'b1);
    endtask : frame
    task automatic text(input int c);
        int n;
        n = pfx[c].len();
        host.rx_q.delete();
        apb(A_TEXT, 1'b1, 32'h0000_0200 | 32'(c));
        apb(A_CTRL, 1'b1, 32'h9);
        wait_bytes(n + 4);
        for (int i = 0; i < n; i++) chk("text prefix", host.rx_q[i], pfx[c][i]);
        chk("text body 0", host.rx_q[n], 8'h61);
        chk("text body 1", host.rx_q[n + 1], 8'h62);
        chk("text cr", host.rx_q[n + 2], 8'h0D);
        chk("text lf", host.rx_q[n + 3], 8'h0A);
        irq_clear(32'h2, 1'b0);
    endtask : text
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        apb(A_BAUD, 1'b0, 32'h0);
        chk("baud register", rd, 32'h0000_01B2);
        chk("baud output", baud_div, 16'h01B2);
        apb(12'h020, 1'b0, 32'h0);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        for (int i = 0; i < 2; i++) begin
            flg <= i ? 11'h555 : 11'h2AA;
            apb(A_FLAGS, 1'b0, 32'h0);
            chk("status flags", rd, i ? 32'h555 : 32'h2AA);
        end
        apb(A_MASK, 1'b1, 32'h7);
        apb(A_CTRL, 1'b1, 32'h5);
        irq_clear(32'h4, 1'b1);
        for (int k = 0; k < 22; k++) apb(A_SOL + 12'(4 * k), 1'b1, sw(k));
        apb(A_TBUF, 1'b1, 32'h61);
        apb(A_TBUF + 12'h004, 1'b1, 32'h62);
        frame(11'h7FE, 32'h5);
        chk("port one", port1_en, 1'b1);
        frame(11'h001, 32'h6);
        chk("port three", {port1_en, port3_en}, 2'b01);
        apb(A_MASK, 1'b1, 32'h0);
        for (int c = 0; c < 4; c++) text(c);
        print_verdict();
    end
    initial begin
        #1_000_000;
        num_errors++;
        print_verdict();
    end
endmodule : nsf_formatter_test
bind nsf_formatter nsf_formatter_monitor mon (.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pslverr,
    .filter_init, .filter_converged, .filter_converging, .tilt_excess_flag, .satellite_fix_reject_flag,
    .filter_reset_pending_flag, .mount_estimation_phase_flag, .mount_estimation_done_flag, .tx_data, .tx_valid,
    .tx_ready, .port1_en, .port3_en);
